// [pcitg_defs.svh]
// Constants for the bus target: commands, address window, reset values
`ifndef PCITG_DEFS_SVH
`define PCITG_DEFS_SVH

`define PCITG_AD_W        32
`define PCITG_CBE_W       4
`define PCITG_MEM_AW      4
`define PCITG_MEM_DEPTH   16
`define PCITG_WORD_LSB    2
`define PCITG_WORD_MSB    5
`define PCITG_BASE_LSB    6
`define PCITG_BASE_ADDR   32'h0001_0000
`define PCITG_CMD_MEM_RD  4'h6
`define PCITG_CMD_MEM_WR  4'h7
`define PCITG_AD_RST      32'h0000_0000
`define PCITG_CMD_RST     4'h0
`define PCITG_IDX_RST     4'h0
`define PCITG_IDX_STEP    4'h1
`define PCITG_CLK_HZ      33000000

`endif

// [pcitg_mem.sv]
// Word store behind the bus target, registered read data
`timescale 1ns/1ps
`include "pcitg_defs.svh"

module pcitg_mem
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    // Store side
    pcitg_mem_if.store       mem
);

    logic [`PCITG_AD_W-1:0] words_r [`PCITG_MEM_DEPTH];
    logic [`PCITG_AD_W-1:0] rdata_r;
    logic [`PCITG_AD_W-1:0] rdata_nxt;

    always_comb
    begin
        rdata_nxt = words_r[mem.idx];
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rdata_r <= `PCITG_AD_RST;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // Storage array, no reset needed on contents
    always_ff @(posedge i_clk_sys)
    begin
        if (mem.we)
        begin
            words_r[mem.idx] <= mem.wdata;
        end
    end

    assign mem.rdata = rdata_r;

endmodule : pcitg_mem

// [pcitg_mem_if.sv]
// Carrier between the bus target and its word store
`timescale 1ns/1ps
`include "pcitg_defs.svh"

interface pcitg_mem_if;
    logic                          we;
    logic [`PCITG_MEM_AW-1:0]      idx;
    logic [`PCITG_AD_W-1:0]        wdata;
    logic [`PCITG_AD_W-1:0]        rdata;

    modport master
    (
        output we,
        output idx,
        output wdata,
        input  rdata
    );

    modport store
    (
        input  we,
        input  idx,
        input  wdata,
        output rdata
    );
endinterface : pcitg_mem_if

// [pcitg_mst.sv]
// Bus master model driving the target
`timescale 1ns/1ps
`include "pcitg_defs.svh"

module pcitg_mst
(
    // Clock and wire levels
    input  wire logic        i_clk_sys,
    input  wire logic [31:0] i_ad,
    input  wire logic        i_trdy_n,
    // Master drive
    output logic [31:0]      o_ad,
    output logic [3:0]       o_cbe_n,
    output logic             o_frame_n,
    output logic             o_irdy_n
);
    logic [31:0] rd [4];
    logic        done;

    initial
    begin
        o_ad      = 32'h0;
        o_cbe_n   = 4'hf;
        o_frame_n = 1'b1;
        o_irdy_n  = 1'b1;
    end

    task xfer(input logic [3:0] c, input logic [31:0] a, input int n, input logic slow, input logic [31:0] d);
        int   i;
        int   k;
        logic w;
        logic on;
        w = c == `PCITG_CMD_MEM_WR;
        i = 0;
        k = 0;
        @(posedge i_clk_sys);
        o_frame_n <= 1'b0;
        o_ad      <= a;
        o_cbe_n   <= c;
        @(posedge i_clk_sys);
        while (i < n && k < 12)
        begin
            on = !slow || k >= 2;
            o_irdy_n  <= !on;
            o_frame_n <= on && i == n - 1;
            o_ad      <= (w && on) ? d + 32'(i) : ~o_ad;
            @(posedge i_clk_sys);
            if (on && !i_trdy_n)
            begin
                if (!w)
                    rd[i] = i_ad;
                i++;
            end
            k++;
        end
        done = i == n;
        o_frame_n <= 1'b1;
        o_irdy_n  <= 1'b1;
        o_ad      <= ~o_ad;
        repeat (3) @(posedge i_clk_sys);
    endtask : xfer
endmodule : pcitg_mst

// [pcitg_pkg.sv]
// Types shared by the bus target modules
package pcitg_pkg;

    typedef enum logic [2:0]
    {
        PCITG_IDLE,
        PCITG_WDATA,
        PCITG_RTURN,
        PCITG_RDATA,
        PCITG_RWAIT,
        PCITG_TURN
    } pcitg_state_t;

endpackage : pcitg_pkg

// [pcitg_props.sv]
// Checker for the bus target port timing
`timescale 1ns/1ps
`include "pcitg_defs.svh"

module pcitg_props
(
    // Clock and reset
    input wire logic        i_clk_sys,
    input wire logic        i_nrst,
    // Bus lines
    input wire logic [31:0] i_ad,
    input wire logic [3:0]  i_cbe_n,
    input wire logic        i_frame_n,
    input wire logic        i_irdy_n,
    input wire logic        o_ad_oe_n,
    input wire logic        o_trdy_n,
    input wire logic        o_trdy_oe_n,
    input wire logic        o_serr_oe_n
);
    logic idle_r;
    logic idle_nxt;
    logic aph;
    logic hit;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    always_comb
    begin
        idle_nxt = i_frame_n && i_irdy_n;
        aph      = !i_frame_n && idle_r;
        hit      = i_ad[31:6] == 26'(`PCITG_BASE_ADDR >> 6) && i_cbe_n[3:1] == 3'h3;
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
        if (!i_nrst)
            idle_r <= 1'b1;
        else
            idle_r <= idle_nxt;

    rst_off_a: assert property (disable iff (1'b0) !i_nrst || $rose(i_nrst) |->
        o_ad_oe_n && o_trdy_oe_n && o_trdy_n) else $error("driven in reset");
    serr_off_a: assert property (disable iff (1'b0) o_serr_oe_n)
        else $error("error line driven");
    claim_decode_a: assert property ($fell(o_trdy_oe_n) |-> $past(aph && hit))
        else $error("ready without claim");
    wr_go_a: assert property (aph && hit && i_cbe_n[0] |=> !o_trdy_oe_n && !o_trdy_n)
        else $error("write not ready");
    rd_go_a: assert property (aph && hit && !i_cbe_n[0] |=>
        !o_trdy_oe_n && o_trdy_n ##1 !o_ad_oe_n && !o_trdy_n) else $error("read timing");
    miss_quiet_a: assert property (aph && !hit |=> (o_trdy_oe_n && o_ad_oe_n)[*3])
        else $error("unclaimed answered");
    last_turn_a: assert property (!o_trdy_oe_n && !o_trdy_n && !i_irdy_n && i_frame_n |=>
        o_trdy_n && !o_trdy_oe_n && o_ad_oe_n ##1 o_trdy_oe_n) else $error("bad turnaround");
    read_wait_a: assert property (!o_ad_oe_n && !o_trdy_n && !i_irdy_n && !i_frame_n |=>
        o_trdy_n && !o_ad_oe_n ##1 !o_trdy_n) else $error("read refetch");
    ready_hold_a: assert property (!o_trdy_oe_n && !o_trdy_n && i_irdy_n |=> !o_trdy_n)
        else $error("ready dropped");
    ad_own_a: assert property (!o_ad_oe_n |-> !o_trdy_oe_n)
        else $error("data without ready");
endmodule : pcitg_props

bind pcitg_target pcitg_props u_props (.i_clk_sys, .i_nrst, .i_ad, .i_cbe_n, .i_frame_n,
    .i_irdy_n, .o_ad_oe_n, .o_trdy_n, .o_trdy_oe_n, .o_serr_oe_n);

// [pcitg_target.sv]
// Bus target: address/data phases, ready handshake and turnaround
`timescale 1ns/1ps
`include "pcitg_defs.svh"

module pcitg_target
(
    // Clock and reset
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_nrst,
    // Address/data bus
    input  wire logic [`PCITG_AD_W-1:0]    i_ad,
    output logic      [`PCITG_AD_W-1:0]    o_ad,
    output logic                           o_ad_oe_n,
    // Command and handshake inputs
    input  wire logic [`PCITG_CBE_W-1:0]   i_cbe_n,
    input  wire logic                      i_frame_n,
    input  wire logic                      i_irdy_n,
    // Target ready, three-state
    output logic                           o_trdy_n,
    output logic                           o_trdy_oe_n,
    // System error, open drain
    output logic                           o_serr_n,
    output logic                           o_serr_oe_n
);

    pcitg_mem_if mem_bus ();

    pcitg_mem u_mem
    (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .mem       (mem_bus.store)
    );

    // Sequencer state and registered pin drives
    pcitg_pkg::pcitg_state_t       state_r;
    pcitg_pkg::pcitg_state_t       state_nxt;
    logic [`PCITG_MEM_AW-1:0]      idx_r;
    logic [`PCITG_MEM_AW-1:0]      idx_nxt;
    logic                          frame_prev_r;
    logic                          irdy_prev_r;
    logic                          trdy_n_r;
    logic                          trdy_n_nxt;
    logic                          trdy_oe_n_r;
    logic                          trdy_oe_n_nxt;
    logic                          ad_oe_n_r;
    logic                          ad_oe_n_nxt;
    logic                          we_nxt;
    logic                          start;
    logic                          xfer;
    logic                          hit;
    logic                          serr_oe_n_r;
    logic                          serr_oe_n_nxt;

    // Address falls in this target's window
    function automatic logic addr_hit(input logic [`PCITG_AD_W-1:0] a);
        addr_hit = (a[`PCITG_AD_W-1:`PCITG_BASE_LSB] ==
                    (`PCITG_AD_W-`PCITG_BASE_LSB)'(`PCITG_BASE_ADDR >> `PCITG_BASE_LSB));
    endfunction : addr_hit

    // Address phase follows an idle bus clock
    assign start = !i_frame_n && frame_prev_r && irdy_prev_r;
    assign hit   = addr_hit(i_ad);
    assign xfer  = !i_irdy_n && !trdy_n_r && !trdy_oe_n_r;

    // Sequencer next state and pin drives
    always_comb
    begin
        state_nxt     = state_r;
        idx_nxt       = idx_r;
        trdy_n_nxt    = 1'b1;
        trdy_oe_n_nxt = trdy_oe_n_r;
        ad_oe_n_nxt   = ad_oe_n_r;
        we_nxt        = 1'b0;
        unique case (state_r)
            pcitg_pkg::PCITG_IDLE:
            begin
                trdy_oe_n_nxt = 1'b1;
                ad_oe_n_nxt   = 1'b1;
                if (start && hit)
                begin
                    idx_nxt = i_ad[`PCITG_WORD_MSB:`PCITG_WORD_LSB];
                    if (i_cbe_n == `PCITG_CMD_MEM_WR)
                    begin
                        state_nxt     = pcitg_pkg::PCITG_WDATA;
                        trdy_n_nxt    = 1'b0;
                        trdy_oe_n_nxt = 1'b0;
                    end
                    else if (i_cbe_n == `PCITG_CMD_MEM_RD)
                    begin
                        state_nxt     = pcitg_pkg::PCITG_RTURN;
                        trdy_oe_n_nxt = 1'b0;
                    end
                end
            end
            pcitg_pkg::PCITG_WDATA:
            begin
                trdy_n_nxt = 1'b0;
                if (xfer)
                begin
                    we_nxt  = 1'b1;
                    idx_nxt = idx_r + `PCITG_IDX_STEP;
                    if (i_frame_n)
                    begin
                        state_nxt  = pcitg_pkg::PCITG_TURN;
                        trdy_n_nxt = 1'b1;
                    end
                end
            end
            pcitg_pkg::PCITG_RTURN:
            begin
                // Master releases the lines, read data is fetched
                state_nxt   = pcitg_pkg::PCITG_RDATA;
                trdy_n_nxt  = 1'b0;
                ad_oe_n_nxt = 1'b0;
            end
            pcitg_pkg::PCITG_RDATA:
            begin
                trdy_n_nxt = 1'b0;
                if (xfer)
                begin
                    idx_nxt    = idx_r + `PCITG_IDX_STEP;
                    trdy_n_nxt = 1'b1;
                    if (i_frame_n)
                    begin
                        state_nxt   = pcitg_pkg::PCITG_TURN;
                        ad_oe_n_nxt = 1'b1;
                    end
                    else
                    begin
                        state_nxt = pcitg_pkg::PCITG_RWAIT;
                    end
                end
            end
            pcitg_pkg::PCITG_RWAIT:
            begin
                // Next word not yet in the read register
                state_nxt  = pcitg_pkg::PCITG_RDATA;
                trdy_n_nxt = 1'b0;
            end
            pcitg_pkg::PCITG_TURN:
            begin
                state_nxt     = pcitg_pkg::PCITG_IDLE;
                trdy_oe_n_nxt = 1'b1;
                ad_oe_n_nxt   = 1'b1;
            end
            default:
            begin
                state_nxt     = pcitg_pkg::PCITG_IDLE;
                trdy_oe_n_nxt = 1'b1;
                ad_oe_n_nxt   = 1'b1;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_r      <= pcitg_pkg::PCITG_IDLE;
            idx_r        <= `PCITG_IDX_RST;
            frame_prev_r <= 1'b1;
            irdy_prev_r  <= 1'b1;
            trdy_n_r     <= 1'b1;
            trdy_oe_n_r  <= 1'b1;
            ad_oe_n_r    <= 1'b1;
        end
        else
        begin
            state_r      <= state_nxt;
            idx_r        <= idx_nxt;
            frame_prev_r <= i_frame_n;
            irdy_prev_r  <= i_irdy_n;
            trdy_n_r     <= trdy_n_nxt;
            trdy_oe_n_r  <= trdy_oe_n_nxt;
            ad_oe_n_r    <= ad_oe_n_nxt;
        end
    end

    // System error released, no parity checking here
    always_comb
    begin
        serr_oe_n_nxt = 1'b1;
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            serr_oe_n_r <= 1'b1;
        end
        else
        begin
            serr_oe_n_r <= serr_oe_n_nxt;
        end
    end

    // Write port fed straight from the sampled bus
    assign mem_bus.we    = we_nxt;
    assign mem_bus.idx   = idx_r;
    assign mem_bus.wdata = i_ad;

    // Pin drives come from registers only
    assign o_ad        = mem_bus.rdata;
    assign o_ad_oe_n   = ad_oe_n_r;
    assign o_trdy_n    = trdy_n_r;
    assign o_trdy_oe_n = trdy_oe_n_r;
    // Open drain, level follows its enable
    assign o_serr_n    = serr_oe_n_r;
    assign o_serr_oe_n = serr_oe_n_r;

endmodule : pcitg_target

// [tb.sv]
// Testbench for the bus target
`timescale 1ns/1ps
`include "pcitg_defs.svh"

module tb;
    logic        clk;
    logic        nrst = 1'b1;
    logic [31:0] m_ad;
    logic [31:0] t_ad;
    logic [31:0] ad_w;
    logic [3:0]  cbe_n;
    logic        frame_n;
    logic        irdy_n;
    logic        ad_oe_n;
    logic        trdy_n;
    logic        trdy_oe_n;
    logic        trdy_w;
    logic        serr_n;
    logic        serr_oe_n;
    int          bad_count;
    int          check_count;
    localparam logic [31:0] B = `PCITG_BASE_ADDR;
    localparam logic [31:0] D = 32'hc0de_0100;

    assign ad_w   = ad_oe_n ? m_ad : t_ad;
    assign trdy_w = trdy_oe_n ? 1'b1 : trdy_n;

    pcitg_target u_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_ad(ad_w), .o_ad(t_ad), .o_ad_oe_n(ad_oe_n),
        .i_cbe_n(cbe_n), .i_frame_n(frame_n), .i_irdy_n(irdy_n), .o_trdy_n(trdy_n),
        .o_trdy_oe_n(trdy_oe_n), .o_serr_n(serr_n), .o_serr_oe_n(serr_oe_n));
    pcitg_mst u_mst (.i_clk_sys(clk), .i_ad(ad_w), .i_trdy_n(trdy_w), .o_ad(m_ad),
        .o_cbe_n(cbe_n), .o_frame_n(frame_n), .o_irdy_n(irdy_n));

    task chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk

    task end_sim;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task t_reset;
        chk(ad_oe_n === 1'b1 && trdy_oe_n === 1'b1 && serr_oe_n === 1'b1, "reset drive");
        chk(serr_n === 1'b1, "error line level");
        @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        chk(ad_oe_n === 1'b1 && trdy_oe_n === 1'b1 && trdy_n === 1'b1, "idle after reset");
    endtask : t_reset

    task t_burst;
        u_mst.xfer(`PCITG_CMD_MEM_WR, B + 32'd56, 4, 1'b0, D);
        chk(u_mst.done, "write burst");
        u_mst.xfer(`PCITG_CMD_MEM_RD, B + 32'd56, 4, 1'b1, 32'h0);
        chk(u_mst.done, "read burst");
        for (int i = 0; i < 4; i++)
            chk(u_mst.rd[i] === D + 32'(i), "burst word");
        u_mst.xfer(`PCITG_CMD_MEM_RD, B, 1, 1'b0, 32'h0);
        chk(u_mst.done && u_mst.rd[0] === D + 32'd2, "wrapped word");
    endtask : t_burst

    task t_hold;
        u_mst.xfer(`PCITG_CMD_MEM_WR, B + 32'd20, 1, 1'b1, 32'h0bad_f00d);
        chk(u_mst.done, "slow write");
        u_mst.xfer(`PCITG_CMD_MEM_RD, B + 32'd20, 1, 1'b0, 32'h0);
        chk(u_mst.done && u_mst.rd[0] === 32'h0bad_f00d, "held write");
    endtask : t_hold

    task t_miss;
        u_mst.xfer(`PCITG_CMD_MEM_RD, B + 32'd64, 1, 1'b0, 32'h0);
        chk(!u_mst.done && trdy_oe_n === 1'b1, "outside window");
        u_mst.xfer(4'h2, B, 1, 1'b0, 32'h0);
        chk(!u_mst.done && ad_oe_n === 1'b1, "other command");
    endtask : t_miss

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        bad_count   = 0;
        check_count = 0;
        nrst        <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_burst();
        t_hold();
        t_miss();
        end_sim();
    end
endmodule : tb
